// ---- verilog/logic_stack_rotate_pkg.sv ----
package logic_stack_rotate_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Clocks per machine cycle
    localparam int MC_CLKS = 4;
    // Machine cycles taken by interrupt entry
    localparam int IRQ_CYCLES = 2;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_OR_RN = 8'h48;
    localparam logic [7:0] OP_OR_DIR = 8'h45;
    localparam logic [7:0] OP_OR_RI = 8'h46;
    localparam logic [7:0] OP_OR_IMM = 8'h44;
    localparam logic [7:0] OP_OR_TO_DIR = 8'h42;
    localparam logic [7:0] OP_OR_DIR_IMM = 8'h43;
    localparam logic [7:0] OP_OR_CY_BIT = 8'h72;
    localparam logic [7:0] OP_OR_CY_NBIT = 8'ha0;
    localparam logic [7:0] OP_POP = 8'hd0;
    localparam logic [7:0] OP_PUSH = 8'hc0;
    localparam logic [7:0] OP_SUB_EXIT = 8'h22;
    localparam logic [7:0] OP_INT_EXIT = 8'h32;
    localparam logic [7:0] OP_ROT_L = 8'h23;
    localparam logic [7:0] OP_ROT_LC = 8'h33;
    localparam logic [7:0] OP_ROT_R = 8'h03;
    localparam logic [7:0] OP_ROT_RC = 8'h13;

    // ------------------------------------------------------------
    // Direct address map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ACC = 8'he0;
    localparam logic [7:0] ADDR_PSW = 8'hd0;
    localparam logic [7:0] ADDR_SP = 8'h81;
    localparam logic [7:0] ADDR_PORT = 8'h90;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam int PSW_CY = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] SP_RST = 8'h07;
    localparam logic [7:0] PORT_RST = 8'hff;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] PSW_RST = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ADDR = 3'h0,
        ST_OPC = 3'h1,
        ST_BYTE1 = 3'h3,
        ST_BYTE2 = 3'h2,
        ST_EXEC = 3'h6,
        ST_HOLD = 3'h7
    } state_t;

    typedef struct packed {
        logic [1:0] nbytes;
        logic [1:0] ncyc;
    } instr_info_t;

    typedef struct packed {
        logic req;
        logic high;
        logic [15:0] vector;
    } irq_req_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] program_status_word;
        logic [7:0] sp;
    } core_state_t;

    // Length and duration; unknown opcodes run as 1-byte 1-cycle no-ops
    function automatic instr_info_t instr_info(input logic [7:0] op);
        instr_info_t r;
        r = '{nbytes: 2'h1, ncyc: 2'h1};
        case (op)
            OP_OR_DIR, OP_OR_IMM, OP_OR_TO_DIR: r.nbytes = 2'h2;
            OP_OR_DIR_IMM: r = '{nbytes: 2'h3, ncyc: 2'h2};
            OP_OR_CY_BIT, OP_OR_CY_NBIT, OP_POP, OP_PUSH: r = '{nbytes: 2'h2, ncyc: 2'h2};
            OP_SUB_EXIT, OP_INT_EXIT: r.ncyc = 2'h2;
            default: r = r;
        endcase
        return r;
    endfunction

endpackage

// ---- verilog/logic_stack_rotate_exec.sv ----
module logic_stack_rotate_exec
    import logic_stack_rotate_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    output logic [15:0] code_addr_o,
    input wire logic [7:0] code_data_i,
    input wire logic [7:0] port_pins_i,
    output logic [7:0] port_latch_o,
    input wire irq_req_t irq_i,
    output logic irq_ack_o,
    output logic [1:0] in_service_o,
    output core_state_t core_o,
    output logic retire_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ram_r [0:255];
    state_t state_r;
    state_t state_nxt;
    logic [2:0] ph_r;
    logic [15:0] pc_r;
    logic [15:0] code_addr_r;
    logic [7:0] op_r;
    logic [7:0] b1_r;
    logic [7:0] b2_r;
    logic [7:0] acc_r;
    logic [7:0] psw_r;
    logic [7:0] sp_r;
    logic [7:0] port_r;
    logic irq_r;
    logic hold_r;
    logic ack_r;
    logic retire_r;
    logic [1:0] insvc_r;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One-hot hit on the mapped special locations
    function automatic logic [3:0] sfr_hit(input logic [7:0] addr);
        logic [3:0] h;
        h = 4'h0;
        case (addr)
            ADDR_ACC: h = 4'h1;
            ADDR_PSW: h = 4'h2;
            ADDR_SP: h = 4'h4;
            ADDR_PORT: h = 4'h8;
            default: h = 4'h0;
        endcase
        return h;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    instr_info_t info_fetch;
    instr_info_t info_cur;
    assign info_fetch = instr_info(code_data_i);
    assign info_cur = instr_info(op_r);

    wire run = (state_r == ST_EXEC) && !irq_r;
    wire irq_run = (state_r == ST_EXEC) && irq_r;

    wire or_rn = run && (op_r[7:3] == OP_OR_RN[7:3]);
    wire or_dir = run && (op_r == OP_OR_DIR);
    wire or_ri = run && (op_r[7:1] == OP_OR_RI[7:1]);
    wire or_imm = run && (op_r == OP_OR_IMM);
    wire or_to_dir = run && (op_r == OP_OR_TO_DIR);
    wire or_dir_imm = run && (op_r == OP_OR_DIR_IMM);
    wire or_cy = run && (op_r == OP_OR_CY_BIT);
    wire or_ncy = run && (op_r == OP_OR_CY_NBIT);
    wire pop = run && (op_r == OP_POP);
    wire push = run && (op_r == OP_PUSH);
    wire sub_exit = run && (op_r == OP_SUB_EXIT);
    wire int_exit = run && (op_r == OP_INT_EXIT);
    wire rot_l = run && (op_r == OP_ROT_L);
    wire rot_lc = run && (op_r == OP_ROT_LC);
    wire rot_r = run && (op_r == OP_ROT_R);
    wire rot_rc = run && (op_r == OP_ROT_RC);

    wire or_acc = or_rn || or_dir || or_ri || or_imm;
    wire is_ret = sub_exit || int_exit;
    wire bit_op = or_cy || or_ncy;
    wire rmw = or_to_dir || or_dir_imm;

    // ------------------------------------------------------------
    // Operand fetch
    // ------------------------------------------------------------
    wire [7:0] rn_addr = {3'h0, psw_r[4:3], op_r[2:0]};
    wire [7:0] ri_addr = {3'h0, psw_r[4:3], 2'h0, op_r[0]};
    wire [7:0] bit_byte = b1_r[7] ? {b1_r[7:3], 3'h0} : (BIT_RAM_BASE + {4'h0, b1_r[6:3]});
    wire [7:0] d_addr = bit_op ? bit_byte : b1_r;
    wire [3:0] d_hit = sfr_hit(d_addr);

    // Modify-write of the port starts from the latch
    wire [7:0] port_src = rmw ? port_r : port_pins_i;

    wire [7:0] sfr_val =
        d_hit[0] ? acc_r :
        d_hit[1] ? psw_r :
        d_hit[2] ? sp_r :
        d_hit[3] ? port_src :
        8'h00;
    wire [7:0] dir_val = d_addr[7] ? sfr_val : ram_r[d_addr];
    wire bit_val = dir_val[b1_r[2:0]];

    wire [7:0] or_src =
        or_rn ? ram_r[rn_addr] :
        or_ri ? ram_r[ram_r[ri_addr]] :
        or_dir ? dir_val :
        b1_r;

    wire [7:0] sp_inc = sp_r + 8'h01;
    wire [7:0] sp_inc2 = sp_r + 8'h02;
    wire [7:0] sp_dec = sp_r - 8'h01;

    // ------------------------------------------------------------
    // Direct write path
    // ------------------------------------------------------------
    wire wr_en = rmw || pop;
    // Mask OR: only ones in the mask change the target
    wire [7:0] wr_data =
        pop ? ram_r[sp_r] :
        (dir_val | (or_to_dir ? acc_r : b2_r));
    wire wr_acc = wr_en && d_hit[0];
    wire wr_psw = wr_en && d_hit[1];
    wire wr_sp = wr_en && d_hit[2];
    wire wr_port = wr_en && d_hit[3];

    // ------------------------------------------------------------
    // Accumulator and flags
    // ------------------------------------------------------------
    wire [7:0] acc_base =
        or_acc ? (acc_r | or_src) :
        rot_l ? {acc_r[6:0], acc_r[7]} :
        rot_lc ? {acc_r[6:0], psw_r[PSW_CY]} :
        rot_r ? {acc_r[0], acc_r[7:1]} :
        rot_rc ? {psw_r[PSW_CY], acc_r[7:1]} :
        acc_r;
    wire [7:0] acc_nxt = wr_acc ? wr_data : acc_base;

    // Accumulator ORs never reach the carry; bit ORs touch nothing else
    wire cy_base =
        rot_lc ? acc_r[7] :
        rot_rc ? acc_r[0] :
        or_cy ? (psw_r[PSW_CY] | bit_val) :
        or_ncy ? (psw_r[PSW_CY] | ~bit_val) :
        psw_r[PSW_CY];

    // Parity tracks the accumulator, even over a direct write to the word
    wire [7:0] psw_nxt =
        wr_psw ? {wr_data[7:1], ^acc_nxt} :
        {cy_base, psw_r[6:1], ^acc_nxt};

    // ------------------------------------------------------------
    // Stack index and program counter
    // ------------------------------------------------------------
    wire [7:0] sp_base =
        push ? sp_inc :
        pop ? sp_dec :
        is_ret ? (sp_r - 8'h02) :
        irq_run ? sp_inc2 :
        sp_r;
    // Pull into the index lands after the decrement
    wire [7:0] sp_nxt = wr_sp ? wr_data : sp_base;

    wire fetching = (state_r == ST_OPC) || (state_r == ST_BYTE1) || (state_r == ST_BYTE2);
    wire [15:0] pc_nxt =
        fetching ? (pc_r + 16'h0001) :
        is_ret ? {ram_r[sp_r], ram_r[sp_dec]} :
        irq_run ? {b2_r, b1_r} :
        pc_r;

    wire [7:0] port_nxt = wr_port ? wr_data : port_r;

    // ------------------------------------------------------------
    // RAM ports
    // ------------------------------------------------------------
    wire ram_we_a = push || irq_run || (wr_en && !d_addr[7]);
    wire [7:0] ram_addr_a = (push || irq_run) ? sp_inc : d_addr;
    wire [7:0] ram_data_a =
        push ? dir_val :
        irq_run ? pc_r[7:0] :
        wr_data;
    wire ram_we_b = irq_run;

    // ------------------------------------------------------------
    // Interrupt acceptance
    // ------------------------------------------------------------
    // A pending request waits one instruction after an interrupt exit
    wire level_ok = irq_i.high ? !insvc_r[1] : (insvc_r == 2'h0);
    wire accept = (state_r == ST_ADDR) && irq_i.req && !hold_r && level_ok;

    wire [1:0] insvc_clr = insvc_r[1] ? 2'h2 : 2'h1;
    wire [1:0] insvc_set = op_r[0] ? 2'h2 : 2'h1;
    wire [1:0] insvc_nxt =
        irq_run ? (insvc_r | insvc_set) :
        int_exit ? (insvc_r & ~insvc_clr) :
        insvc_r;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    wire [2:0] last_ph = irq_r ? 3'(IRQ_CYCLES * MC_CLKS - 1) : 3'(int'(info_cur.ncyc) * MC_CLKS - 1);
    wire last_hit = ((state_r == ST_EXEC) || (state_r == ST_HOLD)) && (ph_r == last_ph);

    always_comb begin
        case (state_r)
            ST_ADDR: state_nxt = accept ? ST_EXEC : ST_OPC;
            ST_OPC: state_nxt = (info_fetch.nbytes > 2'h1) ? ST_BYTE1 : ST_EXEC;
            ST_BYTE1: state_nxt = (info_cur.nbytes == 2'h3) ? ST_BYTE2 : ST_EXEC;
            ST_BYTE2: state_nxt = ST_EXEC;
            ST_EXEC: state_nxt = last_hit ? ST_ADDR : ST_HOLD;
            ST_HOLD: state_nxt = last_hit ? ST_ADDR : ST_HOLD;
            default: state_nxt = ST_ADDR;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= ST_ADDR;
            ph_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            ph_r <= (state_nxt == ST_ADDR) ? 3'h0 : ph_r + 3'h1;
        end
    end

    // Interrupt entry reuses the operand registers for vector and level
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            op_r <= 8'h00;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            irq_r <= 1'b0;
        end else if (accept) begin
            op_r <= {7'h00, irq_i.high};
            b1_r <= irq_i.vector[7:0];
            b2_r <= irq_i.vector[15:8];
            irq_r <= 1'b1;
        end else begin
            if (state_r == ST_ADDR) irq_r <= 1'b0;
            if (state_r == ST_OPC) op_r <= code_data_i;
            if (state_r == ST_BYTE1) b1_r <= code_data_i;
            if (state_r == ST_BYTE2) b2_r <= code_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pc_r <= PC_RST;
            code_addr_r <= PC_RST;
        end else begin
            pc_r <= pc_nxt;
            code_addr_r <= pc_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc_r <= ACC_RST;
            psw_r <= PSW_RST;
            sp_r <= SP_RST;
            port_r <= PORT_RST;
        end else begin
            acc_r <= acc_nxt;
            psw_r <= psw_nxt;
            sp_r <= sp_nxt;
            port_r <= port_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hold_r <= 1'b0;
            insvc_r <= 2'h0;
        end else begin
            if (state_r == ST_ADDR) hold_r <= 1'b0;
            if (int_exit) hold_r <= 1'b1;
            insvc_r <= insvc_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            retire_r <= 1'b0;
        end else begin
            ack_r <= accept;
            retire_r <= last_hit;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int i = 0; i < 256; i++) begin
                ram_r[i] <= 8'h00;
            end
        end else begin
            if (ram_we_a) ram_r[ram_addr_a] <= ram_data_a;
            if (ram_we_b) ram_r[sp_inc2] <= pc_r[15:8];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign code_addr_o = code_addr_r;
    assign port_latch_o = port_r;
    assign irq_ack_o = ack_r;
    assign in_service_o = insvc_r;
    assign core_o = '{acc: acc_r, program_status_word: psw_r, sp: sp_r};
    assign retire_o = retire_r;

endmodule

// ---- bench/logic_stack_rotate_properties.sv ----
module logic_stack_rotate_properties
    import logic_stack_rotate_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] code_addr_o,
    input wire logic [7:0] code_data_i,
    input wire logic [7:0] port_pins_i,
    input wire logic [7:0] port_latch_o,
    input wire irq_req_t irq_i,
    input wire logic irq_ack_o,
    input wire logic [1:0] in_service_o,
    input wire core_state_t core_o,
    input wire logic retire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Snapshot of each instruction at its start
    // ----------------------------------------
    logic [7:0] op_r, acc_r, psw_r, sp_r;
    logic [1:0] ins_r;
    logic ok_r, ret_d_r;
    logic [4:0] cnt_r, exp_clks;
    logic done, cy;
    logic [7:0] acc;
    assign done = retire_o && ok_r;
    assign acc = core_o.acc;
    assign cy = core_o.program_status_word[PSW_CY];
    assign exp_clks = (op_r inside {OP_OR_DIR_IMM, OP_OR_CY_BIT, OP_OR_CY_NBIT, OP_POP, OP_PUSH,
        OP_SUB_EXIT, OP_INT_EXIT}) ? 5'h8 : 5'h4;
    always_ff @(posedge clk_sys_i) begin
        ret_d_r <= retire_o & ~rst_i;
        cnt_r <= (retire_o || rst_i) ? 5'h1 : ((cnt_r == 5'h1f) ? cnt_r : cnt_r + 5'h1);
        if (rst_i) begin
            ok_r <= 1'b0;
        end else if (ret_d_r) begin
            op_r <= code_data_i;
            ok_r <= ~irq_ack_o;
            acc_r <= acc;
            psw_r <= core_o.program_status_word;
            sp_r <= core_o.sp;
            ins_r <= in_service_o;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_quiet;
        !retire_o [*3];
    endsequence
    sequence s_no_ack;
        !irq_ack_o [*4];
    endsequence
    AST_RETIRE_GAP: assert property (retire_o |=> s_quiet) else $error("retire too close");
    AST_CLOCKS: assert property (done |-> cnt_r == exp_clks)
        else $error("wrong instruction length");
    AST_ROT_L: assert property (done && op_r == OP_ROT_L |-> acc == {acc_r[6:0], acc_r[7]} &&
        core_o.program_status_word == psw_r) else $error("left rotate wrong");
    AST_ROT_LC: assert property (done && op_r == OP_ROT_LC |-> acc == {acc_r[6:0], psw_r[PSW_CY]} &&
        cy == acc_r[7]) else $error("left rotate via carry wrong");
    AST_ROT_R: assert property (done && op_r == OP_ROT_R |-> acc == {acc_r[0], acc_r[7:1]} &&
        core_o.program_status_word == psw_r) else $error("right rotate wrong");
    AST_ROT_RC: assert property (done && op_r == OP_ROT_RC |-> acc == {psw_r[PSW_CY], acc_r[7:1]} &&
        cy == acc_r[0]) else $error("right rotate via carry wrong");
    AST_ACC_OR: assert property (done && (op_r[7:3] == 5'h09 || op_r[7:2] == 6'h11) |->
        core_o.program_status_word[7:1] == psw_r[7:1] && (acc & acc_r) == acc_r) else $error("byte or disturbed state");
    AST_SUB_EXIT: assert property (done && op_r == OP_SUB_EXIT |-> core_o.sp == sp_r - 8'h2 &&
        core_o.program_status_word == psw_r) else $error("subroutine exit stack wrong");
    AST_INT_EXIT: assert property (done && op_r == OP_INT_EXIT |-> core_o.sp == sp_r - 8'h2 &&
        core_o.program_status_word == psw_r && in_service_o == (ins_r[1] ? {1'b0, ins_r[0]} : 2'h0))
        else $error("interrupt exit state wrong");
    AST_HOLD_OFF: assert property (done && op_r == OP_INT_EXIT |=> s_no_ack)
        else $error("interrupt taken right after exit");
    AST_PUSH: assert property (done && op_r == OP_PUSH |-> core_o.sp == sp_r + 8'h1 &&
        core_o.program_status_word == psw_r) else $error("stack store index wrong");
    AST_ACK_PULSE: assert property (irq_ack_o |=> !irq_ack_o) else $error("ack longer than one cycle");
endmodule

bind logic_stack_rotate_exec logic_stack_rotate_properties logic_stack_rotate_properties_inst (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .code_addr_o(code_addr_o),
    .code_data_i(code_data_i),
    .port_pins_i(port_pins_i),
    .port_latch_o(port_latch_o),
    .irq_i(irq_i),
    .irq_ack_o(irq_ack_o),
    .in_service_o(in_service_o),
    .core_o(core_o),
    .retire_o(retire_o)
);

// ---- bench/logic_stack_rotate_exec_bench.sv ----
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module logic_stack_rotate_exec_bench
    import logic_stack_rotate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, rst_i, irq_ack_o, retire_o;
    logic [15:0] code_addr_o, prev_addr, ack_addr;
    logic [7:0] code_data_i, port_pins_i, port_latch_o;
    logic [7:0] rom [256];
    logic [1:0] in_service_o;
    irq_req_t irq_i;
    core_state_t core_o;
    int errors = 0, check_count = 0, cyc = 0, ack_n = 0;
    // ----------------------------------------
    // Program memory, design, clock
    // ----------------------------------------
    assign code_data_i = rom[code_addr_o[7:0]];
    logic_stack_rotate_exec logic_stack_rotate_exec_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .code_addr_o(code_addr_o), .code_data_i(code_data_i), .port_pins_i(port_pins_i),
        .port_latch_o(port_latch_o), .irq_i(irq_i), .irq_ack_o(irq_ack_o),
        .in_service_o(in_service_o), .core_o(core_o), .retire_o(retire_o));
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        prev_addr <= code_addr_o;
        if (irq_ack_o === 1'b1) begin
            ack_addr <= prev_addr;
            ack_n <= ack_n + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task ld(input logic [7:0] base, input logic [7:0] b[$]);
        foreach (b[i]) rom[base + 8'(i)] = b[i];
    endtask
    task reset_load(input logic [7:0] b[$]);
        @(posedge clk_sys_i) rst_i <= 1'b1;
        #1;
        foreach (rom[i]) rom[i] = 8'h00;
        ld(8'h00, b);
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
    endtask
    task step(input int clks);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end while (retire_o !== 1'b1 && n < 64);
        if (clks > 0) `CHK("clocks", clks, n)
    endtask
    task run(input int c[$]);
        foreach (c[i]) step(c[i]);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_or;
        reset_load('{8'h44, 8'hc1, 8'h43, 8'h07, 8'h14, 8'h42, 8'h07, 8'hd0, 8'he0, 8'h43, 8'h30, 8'h08,
            8'h45, 8'h30, 8'h43, 8'h01, 8'h20, 8'h49, 8'h43, 8'h20, 8'h02, 8'h47});
        step(0);
        `CHK("acc", 8'hc1, core_o.acc)
        run('{8, 4, 8});
        `CHK("acc", 8'hd5, core_o.acc)
        `CHK("sp", 8'h06, core_o.sp)
        run('{8, 4});
        `CHK("acc", 8'hdd, core_o.acc)
        run('{8, 4});
        `CHK("acc", 8'hfd, core_o.acc)
        run('{8, 4});
        `CHK("acc", 8'hff, core_o.acc)
        `CHK("psw", 8'h00, core_o.program_status_word)
        $display("byte or test done");
    endtask
    task t_bit;
        reset_load('{8'h43, 8'h20, 8'h01, 8'h72, 8'h01, 8'h72, 8'h00, 8'h13, 8'ha0, 8'h00, 8'ha0, 8'h01,
            8'h45, 8'h20});
        run('{0, 8});
        `CHK("carry", 1'b0, core_o.program_status_word[PSW_CY])
        step(8);
        `CHK("carry", 1'b1, core_o.program_status_word[PSW_CY])
        step(4);
        `CHK("acc", 8'h80, core_o.acc)
        step(8);
        `CHK("carry", 1'b0, core_o.program_status_word[PSW_CY])
        step(8);
        `CHK("carry", 1'b1, core_o.program_status_word[PSW_CY])
        step(4);
        `CHK("acc", 8'h81, core_o.acc)
        `CHK("psw", 8'h80, core_o.program_status_word)
        $display("bit or test done");
    endtask
    task t_stack;
        reset_load('{8'hc0, 8'h90, 8'hd0, 8'he0, 8'h44, 8'h0a, 8'hc0, 8'he0, 8'hd0, 8'h90,
            8'h43, 8'h90, 8'h10, 8'hc0, 8'he0, 8'hd0, 8'h81});
        step(0);
        `CHK("sp", 8'h08, core_o.sp)
        step(8);
        `CHK("acc", 8'ha5, core_o.acc)
        `CHK("sp", 8'h07, core_o.sp)
        run('{4, 8, 8});
        `CHK("latch", 8'haf, port_latch_o)
        step(8);
        `CHK("latch", 8'hbf, port_latch_o)
        run('{8, 8});
        `CHK("sp", 8'haf, core_o.sp)
        $display("stack test done");
    endtask
    task t_ret;
        reset_load('{8'h44, 8'h40, 8'hc0, 8'he0, 8'h44, 8'h01, 8'hc0, 8'he0, 8'h22});
        ld(8'h40, '{8'h23, 8'h33, 8'h03, 8'h13});
        run('{0, 8, 4, 8, 8});
        `CHK("sp", 8'h07, core_o.sp)
        `CHK("pc", 16'h4140, code_addr_o)
        step(4);
        `CHK("acc", 8'h82, core_o.acc)
        step(4);
        `CHK("acc cy", 9'h104, {core_o.program_status_word[PSW_CY], core_o.acc})
        step(4);
        `CHK("acc cy", 9'h102, {core_o.program_status_word[PSW_CY], core_o.acc})
        step(4);
        `CHK("acc cy", 9'h081, {core_o.program_status_word[PSW_CY], core_o.acc})
        $display("return and rotate test done");
    endtask
    task t_irq;
        logic [15:0] ret_pc;
        reset_load('{8'h00});
        ld(8'h40, '{8'h44, 8'h80, 8'h33, 8'h32});
        irq_i <= '{req: 1'b1, high: 1'b0, vector: 16'h0040};
        while (ack_n < 1 && cyc < 4000) step(0);
        ret_pc = ack_addr;
        step(0);
        `CHK("in service", 2'h1, in_service_o)
        run('{4, 8});
        `CHK("pc", ret_pc, code_addr_o)
        `CHK("in service", 2'h0, in_service_o)
        `CHK("carry", 1'b1, core_o.program_status_word[PSW_CY])
        while (ack_n < 2 && cyc < 4000) step(0);
        `CHK("next accept", ret_pc + 16'h1, ack_addr)
        @(posedge clk_sys_i) irq_i <= '0;
        $display("interrupt test done");
    endtask
    initial begin
        rst_i = 1'b1;
        port_pins_i = 8'ha5;
        irq_i = '0;
        t_or();
        t_bit();
        t_stack();
        t_ret();
        t_irq();
        print_verdict();
    end
endmodule
